// [hdl/gimcb_config_bank.sv]
// Pin pair and local bus master configuration bank with its pin logic.
// Register port comes from the local target or the control channel.
`default_nettype none

module gimcb_config_bank
   import gimcb_pkg::*;
#(
   parameter int WD_FAST_LIM = WD_FAST_CYC,
   parameter int WD_SLOW_LIM = WD_SLOW_CYC,
   parameter int RECOV_HALF  = RECOV_HALF_CYC
) (
   input  wire logic           mclk,
   input  wire logic           resetn,
   input  wire gimcb_reg_req_t regReq,
   output var  logic [7:0]     regRdData,
   output var  logic           regWrRejected,
   input  wire logic           fwdReq,
   output var  logic           fwdReqOut,
   input  wire logic           farLevelTwo,
   input  wire logic           farLevelThree,
   output var  gimcb_pin_t     pinTwo,
   output var  gimcb_pin_t     pinThree,
   input  wire logic           pinThreeIn,
   output var  logic           pinThreeLevel,
   input  wire logic           mstSclFall,
   input  wire logic           mstSdaLevel,
   input  wire logic           sclPinIn,
   input  wire logic           sdaPinIn,
   output var  logic           sdaOe,
   output var  logic           sclOe,
   output var  logic           busFree
);

   gimcb_bank_state_t s_reg;
   gimcb_bank_state_t s_next;
   logic              pinHit;
   logic              mstHit;
   logic              lockHit;

   // Cycles to load so the new SDA shows exactly the nominal delay later
   function automatic logic [5:0] sdaLoad(input logic [1:0] code);
      int cyc;
      cyc = SDA_BASE_CYC + SDA_STEP_CYC * int'(code) - 2;
      return 6'(cyc);
   endfunction

   function automatic logic hitAddr(input gimcb_reg_req_t r,
                                    input logic [7:0] a);
      return r.addr == a;
   endfunction

   // ****************************************************************
   // Register access and pin logic
   // ****************************************************************
   always_comb begin
      s_next = s_reg;
      pinHit = hitAddr(regReq, ADDR_PIN_CFG);
      mstHit = hitAddr(regReq, ADDR_MST_CFG);
      lockHit = regReq.wr && regReq.remote && s_reg.mstCfg[LOCK_BIT]
                && (pinHit || mstHit);
      s_next.wrReject = lockHit;

      if (regReq.wr && !lockHit) begin
         if (pinHit) begin
            s_next.pinCfg = regReq.data;
         end
         if (mstHit) begin
            s_next.mstCfg = regReq.data & MST_CFG_WMASK;
         end
      end

      if (regReq.rd) begin
         if (pinHit) begin
            s_next.rdData = s_reg.pinCfg;
         end else if (mstHit) begin
            s_next.rdData = s_reg.mstCfg;
         end else begin
            s_next.rdData = 8'h00;
         end
      end

      s_next.fwdOut = fwdReq;

      // Pin levels from outside: two flops before use
      s_next.p3Sync  = {s_reg.p3Sync[0], pinThreeIn};
      s_next.sclSync = {s_reg.sclSync[0], sclPinIn};
      s_next.sdaSync = {s_reg.sdaSync[0], sdaPinIn};
      s_next.pinThreeLevel = s_reg.p3Sync[1];

      s_next.pinTwo.level = s_reg.pinCfg[PIN2_FAR_BIT] ? farLevelTwo
                          : s_reg.pinCfg[PIN2_LEVEL_BIT];
      s_next.pinThree.level = s_reg.pinCfg[PIN3_FAR_BIT] ? farLevelThree
                            : s_reg.pinCfg[PIN3_LEVEL_BIT];
      // Enable gates the driver; pin three also needs output direction or far mode
      s_next.pinTwo.oe = s_reg.pinCfg[PIN2_ON_BIT];
      s_next.pinThree.oe = s_reg.pinCfg[PIN3_ON_BIT]
                         && (s_reg.pinCfg[PIN3_FAR_BIT]
                             || !s_reg.pinCfg[PIN3_DIR_BIT]);

      // SDA change delayed after SCL fall
      if (mstSclFall) begin
         s_next.sdaCnt = sdaLoad(s_reg.mstCfg[SDA_DLY_MSB:SDA_DLY_LSB]);
         s_next.sdaPending = 1'b1;
         s_next.sdaVal = mstSdaLevel;
      end else if (s_reg.sdaPending) begin
         if (s_reg.sdaCnt == 6'h00) begin
            s_next.sdaPending = 1'b0;
            // Open drain: enable pulls the line low
            s_next.sdaOe = !s_reg.sdaVal;
         end else begin
            s_next.sdaCnt = s_reg.sdaCnt - 6'h01;
         end
      end

      if (!resetn) begin
         s_next = '0;
         s_next.pinCfg = PIN_CFG_RST;
         s_next.mstCfg = MST_CFG_RST;
      end
   end

   always_ff @(posedge mclk) begin
      s_reg <= s_next;
   end

   assign regRdData     = s_reg.rdData;
   assign regWrRejected = s_reg.wrReject;
   assign fwdReqOut     = s_reg.fwdOut;
   assign pinTwo        = s_reg.pinTwo;
   assign pinThree      = s_reg.pinThree;
   assign pinThreeLevel = s_reg.pinThreeLevel;
   assign sdaOe         = s_reg.sdaOe;

   // ****************************************************************
   // Bus watchdog
   // ****************************************************************
   // Own SCL/SDA drive counts as activity too; it keeps the timer honest
   gimcb_bus_watchdog #(
      .FAST_LIM (WD_FAST_LIM),
      .SLOW_LIM (WD_SLOW_LIM),
      .HALF_LIM (RECOV_HALF)
   ) u_watchdog (
      .mclk     (mclk),
      .resetn   (resetn),
      .sclLevel (s_reg.sclSync[1]),
      .sdaLevel (s_reg.sdaSync[1]),
      .wdOff    (s_reg.mstCfg[WD_OFF_BIT]),
      .wdFast   (s_reg.mstCfg[WD_FAST_BIT]),
      .busFree  (busFree),
      .sclOe    (sclOe)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   local_drive_a: assert property (
      s_reg.pinCfg[PIN3_ON_BIT] && !s_reg.pinCfg[PIN3_FAR_BIT]
      && !s_reg.pinCfg[PIN3_DIR_BIT]
      |=> pinThree.oe
          && pinThree.level == $past(s_reg.pinCfg[PIN3_LEVEL_BIT]))
      else $error("pin three not driven with local level");
   far_follow_a: assert property (
      s_reg.pinCfg[PIN2_FAR_BIT] && s_reg.pinCfg[PIN2_ON_BIT]
      |=> pinTwo.oe && pinTwo.level == $past(farLevelTwo))
      else $error("pin two not following far level");
   tristate_pin_a: assert property (
      !s_reg.pinCfg[PIN3_ON_BIT] || (s_reg.pinCfg[PIN3_DIR_BIT]
      && !s_reg.pinCfg[PIN3_FAR_BIT]) |=> !pinThree.oe)
      else $error("pin three driven while off or input");
   sda_delay_a: assert property (
      mstSclFall && s_reg.mstCfg[SDA_DLY_MSB:SDA_DLY_LSB] == 2'b00
      ##1 !mstSclFall [*8]
      |-> ##27 sdaOe == !$past(mstSdaLevel, 35))
      else $error("SDA delay not 350 ns at code zero");
   remote_lock_a: assert property (
      regReq.wr && regReq.remote && s_reg.mstCfg[LOCK_BIT]
      && hitAddr(regReq, ADDR_PIN_CFG)
      |=> regWrRejected && $stable(s_reg.pinCfg))
      else $error("locked remote write took effect");
   forward_pass_a: assert property (
      fwdReq |=> fwdReqOut)
      else $error("forwarded access held back");
   reserved_zero_a: assert property (
      regReq.rd && hitAddr(regReq, ADDR_MST_CFG) |=> regRdData[7:5] == 3'h0)
      else $error("reserved bits read non-zero");
   write_back_a: assert property (
      regReq.wr && !regReq.remote && hitAddr(regReq, ADDR_PIN_CFG)
      |=> s_reg.pinCfg == $past(regReq.data))
      else $error("written value not stored");

   two_local_a: assert property (
      s_reg.pinCfg[PIN2_ON_BIT] && !s_reg.pinCfg[PIN2_FAR_BIT]
      |=> pinTwo.oe
          && pinTwo.level == $past(s_reg.pinCfg[PIN2_LEVEL_BIT]))
      else $error("pin two not driven with local level");

   three_far_a: assert property (
      s_reg.pinCfg[PIN3_ON_BIT] && s_reg.pinCfg[PIN3_FAR_BIT]
      |=> pinThree.oe && pinThree.level == $past(farLevelThree))
      else $error("pin three not following far level");

   two_tristate_a: assert property (
      !s_reg.pinCfg[PIN2_ON_BIT] |=> !pinTwo.oe)
      else $error("pin two driven while off");

   // Longer codes only stretch the wait; a new fall restarts it
   sda_code1_a: assert property (
      mstSclFall && s_reg.mstCfg[SDA_DLY_MSB:SDA_DLY_LSB] == 2'b01
      ##1 !mstSclFall [*8]
      |-> ##32 sdaOe == !$past(mstSdaLevel, 40))
      else $error("SDA delay not 400 ns at code one");

   sda_code2_a: assert property (
      mstSclFall && s_reg.mstCfg[SDA_DLY_MSB:SDA_DLY_LSB] == 2'b10
      ##1 !mstSclFall [*8]
      |-> ##37 sdaOe == !$past(mstSdaLevel, 45))
      else $error("SDA delay not 450 ns at code two");

   sda_code3_a: assert property (
      mstSclFall && s_reg.mstCfg[SDA_DLY_MSB:SDA_DLY_LSB] == 2'b11
      ##1 !mstSclFall [*8]
      |-> ##42 sdaOe == !$past(mstSdaLevel, 50))
      else $error("SDA delay not 500 ns at code three");

   sda_hold_a: assert property (
      !s_reg.sdaPending |=> $stable(sdaOe))
      else $error("SDA moved with no change pending");

   lock_master_a: assert property (
      regReq.wr && regReq.remote && s_reg.mstCfg[LOCK_BIT]
      && hitAddr(regReq, ADDR_MST_CFG)
      |=> regWrRejected && $stable(s_reg.mstCfg))
      else $error("locked remote write changed master config");

   open_remote_a: assert property (
      regReq.wr && regReq.remote && !s_reg.mstCfg[LOCK_BIT]
      && hitAddr(regReq, ADDR_PIN_CFG)
      |=> !regWrRejected && s_reg.pinCfg == $past(regReq.data))
      else $error("unlocked remote write refused");

   local_accept_a: assert property (
      regReq.wr && !regReq.remote |=> !regWrRejected)
      else $error("local write refused");

   reject_cause_a: assert property (
      regWrRejected |-> $past(regReq.wr) && $past(regReq.remote))
      else $error("reject pulse without remote write");

   forward_copy_a: assert property (
      !fwdReq |=> !fwdReqOut)
      else $error("forwarded request invented");

   master_mask_a: assert property (
      regReq.wr && !lockHit && hitAddr(regReq, ADDR_MST_CFG)
      |=> s_reg.mstCfg == ($past(regReq.data) & MST_CFG_WMASK))
      else $error("master config write not masked");

   read_pin_a: assert property (
      regReq.rd && hitAddr(regReq, ADDR_PIN_CFG)
      |=> regRdData == $past(s_reg.pinCfg))
      else $error("pin config read back wrong");

   read_master_a: assert property (
      regReq.rd && hitAddr(regReq, ADDR_MST_CFG)
      |=> regRdData == $past(s_reg.mstCfg))
      else $error("master config read back wrong");

   read_other_a: assert property (
      regReq.rd && !hitAddr(regReq, ADDR_PIN_CFG)
      && !hitAddr(regReq, ADDR_MST_CFG) |=> regRdData == 8'h00)
      else $error("unmapped read not zero");

   read_hold_a: assert property (
      !regReq.rd |=> $stable(regRdData))
      else $error("read data moved without a read");

   reject_c: cover property (regWrRejected);
   drive_c: cover property ($rose(pinThree.oe));
   delay_c: cover property (mstSclFall ##[1:60] $changed(sdaOe));

endmodule // gimcb_config_bank

`default_nettype wire

// [hdl/gimcb_pkg.sv]
// Shared constants and types of the pin and local-bus-master config bank.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
`default_nettype none

package gimcb_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_PIN_CFG = 8'h0e;
   localparam logic [7:0] ADDR_MST_CFG = 8'h0f;

   localparam int PIN3_LEVEL_BIT = 7;
   localparam int PIN3_FAR_BIT   = 6;
   localparam int PIN3_DIR_BIT   = 5;
   localparam int PIN3_ON_BIT    = 4;
   localparam int PIN2_LEVEL_BIT = 3;
   localparam int PIN2_FAR_BIT   = 2;
   localparam int PIN2_ON_BIT    = 0;
   localparam int SDA_DLY_LSB    = 3;
   localparam int SDA_DLY_MSB    = 4;
   localparam int LOCK_BIT       = 2;
   localparam int WD_FAST_BIT    = 1;
   localparam int WD_OFF_BIT     = 0;

   localparam logic [7:0] PIN_CFG_RST   = 8'h35;
   localparam logic [7:0] MST_CFG_RST   = 8'h00;
   localparam logic [7:0] MST_CFG_WMASK = 8'h1f;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SDA_BASE_NS    = 350;
   localparam int SDA_STEP_NS    = 50;
   localparam int SDA_BASE_CYC   = SDA_BASE_NS / CLK_PERIOD_NS;
   localparam int SDA_STEP_CYC   = SDA_STEP_NS / CLK_PERIOD_NS;
   localparam int WD_FAST_US     = 50;
   localparam int WD_SLOW_MS     = 1000;
   localparam int WD_FAST_CYC    = WD_FAST_US * 1000 / CLK_PERIOD_NS;
   localparam int WD_SLOW_CYC    = WD_SLOW_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RECOV_HALF_NS  = 5000;
   localparam int RECOV_HALF_CYC = RECOV_HALF_NS / CLK_PERIOD_NS;
   localparam int RECOV_PULSES   = 9;
   localparam int WD_CNT_W       = 27;
   localparam int HALF_W         = 16;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      GIMCB_RC_IDLE = 2'b00,
      GIMCB_RC_LOW  = 2'b01,
      GIMCB_RC_HIGH = 2'b11
   } gimcb_rec_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       remote;
      logic [7:0] addr;
      logic [7:0] data;
   } gimcb_reg_req_t;

   typedef struct packed {
      logic level;
      logic oe;
   } gimcb_pin_t;

   typedef struct packed {
      logic [7:0] pinCfg;
      logic [7:0] mstCfg;
      logic [7:0] rdData;
      logic       wrReject;
      logic       fwdOut;
      gimcb_pin_t pinTwo;
      gimcb_pin_t pinThree;
      logic       pinThreeLevel;
      logic [1:0] p3Sync;
      logic [1:0] sclSync;
      logic [1:0] sdaSync;
      logic [5:0] sdaCnt;
      logic       sdaPending;
      logic       sdaVal;
      logic       sdaOe;
   } gimcb_bank_state_t;

   typedef struct packed {
      gimcb_rec_t          st;
      logic [WD_CNT_W-1:0] cnt;
      logic [HALF_W-1:0]   halfCnt;
      logic [3:0]          pulseCnt;
      logic                sclPrev;
      logic                sdaPrev;
      logic                busFree;
      logic                sclOe;
   } gimcb_wd_state_t;

endpackage

`default_nettype wire

// [hdl/gimcb_bus_watchdog.sv]
// Local bus watchdog: idle timer, free-bus flag and nine-clock recovery.
// Expects synchronised SCL and SDA levels on the mclk domain.
`default_nettype none

module gimcb_bus_watchdog
   import gimcb_pkg::*;
#(
   parameter int FAST_LIM  = WD_FAST_CYC,
   parameter int SLOW_LIM  = WD_SLOW_CYC,
   parameter int HALF_LIM  = RECOV_HALF_CYC
) (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic sclLevel,
   input  wire logic sdaLevel,
   input  wire logic wdOff,
   input  wire logic wdFast,
   output var  logic busFree,
   output var  logic sclOe
);

   localparam logic [WD_CNT_W-1:0] FAST_END = WD_CNT_W'(FAST_LIM - 1);
   localparam logic [WD_CNT_W-1:0] SLOW_END = WD_CNT_W'(SLOW_LIM - 1);
   localparam logic [HALF_W-1:0]   HALF_END = HALF_W'(HALF_LIM - 1);
   localparam logic [3:0]          LAST_PULSE = 4'(RECOV_PULSES - 1);

   gimcb_wd_state_t s_reg;
   gimcb_wd_state_t s_next;
   logic            act;
   logic            expire;

   // ****************************************************************
   // Idle timer and recovery sequencer
   // ****************************************************************
   always_comb begin
      s_next = s_reg;
      act = (sclLevel != s_reg.sclPrev) || (sdaLevel != s_reg.sdaPrev);
      expire = (s_reg.cnt == (wdFast ? FAST_END : SLOW_END));
      s_next.sclPrev = sclLevel;
      s_next.sdaPrev = sdaLevel;
      case (s_reg.st)
         GIMCB_RC_IDLE: begin
            if (act || wdOff) begin
               s_next.cnt = '0;
               s_next.busFree = 1'b0;
            end else if (expire) begin
               s_next.cnt = '0;
               if (sdaLevel) begin
                  s_next.busFree = 1'b1;
               end else begin
                  s_next.st = GIMCB_RC_LOW;
                  s_next.sclOe = 1'b1;
                  s_next.halfCnt = '0;
                  s_next.pulseCnt = '0;
               end
            end else if (!s_reg.busFree) begin
               s_next.cnt = s_reg.cnt + 1'b1;
            end
         end
         GIMCB_RC_LOW: begin
            s_next.halfCnt = s_reg.halfCnt + 1'b1;
            if (s_reg.halfCnt == HALF_END) begin
               s_next.halfCnt = '0;
               s_next.sclOe = 1'b0;
               s_next.st = GIMCB_RC_HIGH;
            end
         end
         GIMCB_RC_HIGH: begin
            s_next.halfCnt = s_reg.halfCnt + 1'b1;
            if (s_reg.halfCnt == HALF_END) begin
               s_next.halfCnt = '0;
               if (s_reg.pulseCnt == LAST_PULSE) begin
                  s_next.st = GIMCB_RC_IDLE;
                  s_next.cnt = '0;
               end else begin
                  s_next.pulseCnt = s_reg.pulseCnt + 1'b1;
                  s_next.sclOe = 1'b1;
                  s_next.st = GIMCB_RC_LOW;
               end
            end
         end
         default: begin
            s_next.st = GIMCB_RC_IDLE;
            s_next.sclOe = 1'b0;
         end
      endcase
      if (wdOff) begin
         s_next.st = GIMCB_RC_IDLE;
         s_next.sclOe = 1'b0;
         s_next.cnt = '0;
      end
      if (!resetn) begin
         s_next = '0;
      end
   end

   always_ff @(posedge mclk) begin
      s_reg <= s_next;
   end

   assign busFree = s_reg.busFree;
   assign sclOe   = s_reg.sclOe;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   wd_disable_a: assert property (
      wdOff |=> s_reg.st == GIMCB_RC_IDLE && !sclOe && s_reg.cnt == '0)
      else $error("watchdog kept running while disabled");
   free_detect_a: assert property (
      s_reg.st == GIMCB_RC_IDLE && expire && !act && !wdOff && sdaLevel
      |=> busFree)
      else $error("quiet high bus not flagged free");
   fast_expiry_a: assert property (
      s_reg.st == GIMCB_RC_IDLE && wdFast && s_reg.cnt == FAST_END
      && !act && !wdOff && !sdaLevel |=> sclOe)
      else $error("fast expiry missed");
   nine_pulses_a: assert property (
      s_reg.st == GIMCB_RC_HIGH && s_reg.halfCnt == HALF_END
      && s_reg.pulseCnt == LAST_PULSE && !wdOff
      |=> s_reg.st == GIMCB_RC_IDLE && !sclOe)
      else $error("recovery did not stop after nine clocks");
   pulse_bound_a: assert property (
      s_reg.pulseCnt <= LAST_PULSE)
      else $error("recovery pulse count overran");
   recover_c: cover property ($rose(sclOe));
   free_c: cover property ($rose(busFree));

endmodule // gimcb_bus_watchdog

`default_nettype wire

// [testbench/gimcb_bus_partner.sv]
// Local bus partner: pulled-up SCL and SDA wires and a stuck target.
// Assumes open-drain enables from the bank, high meaning pull low.
`default_nettype none

module gimcb_bus_partner (
   input  wire logic       mclk,
   input  wire logic       sclOe,
   input  wire logic       sdaOe,
   input  wire logic       sdaStuck,
   input  wire logic       clrCount,
   output var  logic       sclPinIn,
   output var  logic       sdaPinIn,
   output var  logic [7:0] sclPulses
);
   timeunit 1ns;
   timeprecision 1ps;

   logic sclPrev = 1'b1;

   // Pull-ups win unless some party pulls low
   always_comb sclPinIn = !sclOe;
   always_comb sdaPinIn = !(sdaOe || sdaStuck);

   // Pulse count is unknown until the bench clears it once

   // Counts SCL falls so recovery clocks can be judged
   always @(posedge mclk) begin
      if (clrCount) begin
         sclPulses <= 8'h00;
      end else if (sclPrev && !sclPinIn) begin
         sclPulses <= sclPulses + 8'h01;
      end
      sclPrev <= sclPinIn;
   end
endmodule // gimcb_bus_partner

`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench of the pin and local-bus-master config bank.
// Assumes the package and the bank are compiled first.
`default_nettype none

module testbench;
   import gimcb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // Shortened watchdog counts keep the run brief
   localparam int FAST = 40;
   localparam int SLOW = 80;
   localparam int HALF = 4;

   logic           mclk          = 1'b0;
   logic           resetn        = 1'b0;
   gimcb_reg_req_t regReq        = '0;
   logic           fwdReq        = 1'b0;
   logic           farLevelTwo   = 1'b1;
   logic           farLevelThree = 1'b0;
   logic           pinThreeIn    = 1'b0;
   logic           mstSclFall    = 1'b0;
   logic           mstSdaLevel   = 1'b1;
   logic           sdaStuck      = 1'b0;
   logic           clrCount      = 1'b0;
   logic [7:0]     regRdData, sclPulses;
   logic           regWrRejected, fwdReqOut, pinThreeLevel;
   logic           sdaOe, sclOe, busFree, sclPinIn, sdaPinIn;
   gimcb_pin_t     pinTwo, pinThree;
   int             badCount      = 0;
   int             numChecks     = 0;

   always #5 mclk = !mclk;

   gimcb_config_bank #(.WD_FAST_LIM(FAST), .WD_SLOW_LIM(SLOW),
                       .RECOV_HALF(HALF)) i_gimcb_config_bank (
      .mclk(mclk), .resetn(resetn), .regReq(regReq),
      .regRdData(regRdData), .regWrRejected(regWrRejected),
      .fwdReq(fwdReq), .fwdReqOut(fwdReqOut),
      .farLevelTwo(farLevelTwo), .farLevelThree(farLevelThree),
      .pinTwo(pinTwo), .pinThree(pinThree), .pinThreeIn(pinThreeIn),
      .pinThreeLevel(pinThreeLevel), .mstSclFall(mstSclFall),
      .mstSdaLevel(mstSdaLevel), .sclPinIn(sclPinIn),
      .sdaPinIn(sdaPinIn), .sdaOe(sdaOe), .sclOe(sclOe),
      .busFree(busFree));

   gimcb_bus_partner i_gimcb_bus_partner (
      .mclk(mclk), .sclOe(sclOe), .sdaOe(sdaOe), .sdaStuck(sdaStuck),
      .clrCount(clrCount), .sclPinIn(sclPinIn), .sdaPinIn(sdaPinIn),
      .sclPulses(sclPulses));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d,
                         input logic rem, output logic rej);
      @(posedge mclk);
      regReq <= {1'b1, 1'b0, rem, a, d};
      @(posedge mclk);
      regReq <= '0;
      #1 rej = regWrRejected;
   endtask

   task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regReq <= {1'b0, 1'b1, 1'b0, a, 8'h00};
      @(posedge mclk);
      regReq <= '0;
      #1 check(regRdData, exp);
   endtask

   task automatic fall(input logic lvl);
      @(posedge mclk);
      mstSclFall  <= 1'b1;
      mstSdaLevel <= lvl;
      @(posedge mclk);
      mstSclFall  <= 1'b0;
   endtask

   // Blip on SDA, then cycles of quiet until the bus is judged free
   task automatic free_time(output logic [7:0] n);
      @(posedge mclk);
      sdaStuck <= 1'b1;
      repeat (6) @(posedge mclk);
      sdaStuck <= 1'b0;
      n = 8'h00;
      do begin
         @(posedge mclk);
         n++;
         #1;
      end while (busFree !== 1'b1 && n < 8'd200);
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      reg_chk(ADDR_PIN_CFG, 8'h35);
      reg_chk(ADDR_MST_CFG, 8'h00);
      check({6'h00, pinTwo}, 8'h03);
      check({7'h00, pinThree.oe}, 8'h00);
   endtask

   task automatic t_regs();
      logic rej;
      reg_wr(ADDR_MST_CFG, 8'hff, 1'b0, rej);
      reg_chk(ADDR_MST_CFG, 8'h1f);
      reg_wr(ADDR_PIN_CFG, 8'h02, 1'b0, rej);
      reg_chk(ADDR_PIN_CFG, 8'h02);
      reg_chk(8'h20, 8'h00);
   endtask

   task automatic t_pins();
      logic [3:0] b;
      logic [7:0] c, g;
      logic       rej, e3, x3, x2;
      for (int i = 0; i < 16; i++) begin
         b = i[3:0];
         c = {b[0], b[1], b[2], b[3], !b[0], b[2], 1'b0, b[1] | b[3]};
         @(posedge mclk);
         farLevelTwo   <= b[3];
         farLevelThree <= !b[0];
         pinThreeIn    <= b[1];
         reg_wr(ADDR_PIN_CFG, c, 1'b0, rej);
         repeat (2) @(posedge mclk);
         #1;
         e3 = c[4] & (c[6] | !c[5]);
         x3 = e3 & (c[6] ? !b[0] : c[7]);
         x2 = c[0] & (c[2] ? b[3] : c[3]);
         g = {6'h00, pinThree.oe, e3 & pinThree.level};
         check(g, {6'h00, e3, x3});
         g = {6'h00, pinTwo.oe, c[0] & pinTwo.level};
         check(g, {6'h00, c[0], x2});
         check({7'h00, pinThreeLevel}, {7'h00, b[1]});
      end
   endtask

   task automatic t_lock();
      logic rej;
      reg_wr(ADDR_MST_CFG, 8'h05, 1'b0, rej);
      reg_wr(ADDR_PIN_CFG, 8'h35, 1'b0, rej);
      check({7'h00, rej}, 8'h00);
      reg_wr(ADDR_PIN_CFG, 8'h88, 1'b1, rej);
      check({7'h00, rej}, 8'h01);
      reg_wr(ADDR_MST_CFG, 8'h00, 1'b1, rej);
      check({7'h00, rej}, 8'h01);
      reg_chk(ADDR_PIN_CFG, 8'h35);
      reg_chk(ADDR_MST_CFG, 8'h05);
      @(posedge mclk);
      fwdReq <= 1'b1;
      @(posedge mclk);
      fwdReq <= 1'b0;
      #1 check({7'h00, fwdReqOut}, 8'h01);
      reg_wr(ADDR_MST_CFG, 8'h01, 1'b0, rej);
      reg_wr(ADDR_PIN_CFG, 8'h88, 1'b1, rej);
      reg_chk(ADDR_PIN_CFG, 8'h88);
   endtask

   task automatic t_sda();
      logic       rej;
      logic [7:0] n;
      for (int k = 0; k < 4; k++) begin
         reg_wr(ADDR_MST_CFG, {3'h0, k[1:0], 3'h1}, 1'b0, rej);
         fall(1'b0);
         n = 8'h00;
         do begin
            @(posedge mclk);
            n++;
            #1;
         end while (sdaOe !== 1'b1 && n < 8'd80);
         // Fall task returns one edge after raising the pulse
         check(n + 8'h01, 8'(SDA_BASE_CYC + SDA_STEP_CYC * k));
         fall(1'b1);
         repeat (60) @(posedge mclk);
         #1 check({7'h00, sdaOe}, 8'h00);
      end
   endtask

   task automatic t_wdog();
      logic       rej;
      logic [7:0] n;
      reg_wr(ADDR_MST_CFG, 8'h02, 1'b0, rej);
      free_time(n);
      check({7'h00, n >= FAST && n <= FAST + 8}, 8'h01);
      reg_wr(ADDR_MST_CFG, 8'h00, 1'b0, rej);
      free_time(n);
      check({7'h00, n >= SLOW && n <= SLOW + 8}, 8'h01);
      reg_wr(ADDR_MST_CFG, 8'h01, 1'b0, rej);
      repeat (2) @(posedge mclk);
      #1 check({7'h00, busFree}, 8'h00);
      repeat (SLOW + 20) @(posedge mclk);
      #1 check({7'h00, busFree}, 8'h00);
   endtask

   task automatic t_hung();
      logic rej;
      @(posedge mclk);
      sdaStuck <= 1'b1;
      clrCount <= 1'b1;
      @(posedge mclk);
      clrCount <= 1'b0;
      reg_wr(ADDR_MST_CFG, 8'h02, 1'b0, rej);
      repeat (FAST + 18 * HALF + 20) @(posedge mclk);
      #1 check(sclPulses, 8'h09);
      check({7'h00, busFree}, 8'h00);
      reg_wr(ADDR_MST_CFG, 8'h01, 1'b0, rej);
      @(posedge mclk);
      sdaStuck <= 1'b0;
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_regs();
      t_pins();
      t_lock();
      t_sda();
      t_wdog();
      t_hung();
      complete_run();
   end

   // Cuts a hang short well past the expected run length
   initial begin
      #200us;
      badCount++;
      complete_run();
   end
endmodule // testbench

`default_nettype wire
